// ### include/nc_pkg.sv
// shared constants and types for the nibble core
package nc_pkg;
  // wishbone register byte offsets
  localparam logic [3:0] REG_CMD   = 4'h0;
  localparam logic [3:0] REG_STATE = 4'h4;
  localparam logic [3:0] REG_PORTS = 4'h8;
  localparam logic [3:0] REG_PROG  = 4'hc;
  // command word fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_IMM_LSB = 8;
  localparam int PROG_PC_LSB = 0;
  // instruction cycle dividers for the two oscillator builds
  localparam logic [3:0] DIV_RES    = 4'h8;
  localparam logic [3:0] DIV_RC     = 4'h4;
  localparam logic [3:0] SAMPLE_PH  = 4'h1;
  localparam logic [1:0] RESET_HOLD = 2'h3;
  // fixed exchange location and pointer limits
  localparam logic [1:0] FIXED_ROW   = 2'h3;
  localparam logic [3:0] FIXED_DIGIT = 4'hf;
  localparam logic [3:0] DP_MAX      = 4'hf;
  localparam logic [3:0] DP_MIN      = 4'h0;
  // feature control bit positions
  localparam int FEAT_CNT    = 0;
  localparam int FEAT_UNUSED = 1;
  localparam int FEAT_DRV    = 2;
  localparam int FEAT_SO     = 3;
  localparam logic LATCH_INIT = 1'b1;

  typedef enum logic [3:0] {
    OP_NOP  = 4'h0,
    OP_ADC  = 4'h1,
    OP_AISC = 4'h2,
    OP_XOR  = 4'h3,
    OP_XCH  = 4'h4,
    OP_XIS  = 4'h5,
    OP_XDS  = 4'h6,
    OP_XAD  = 4'h7,
    OP_CAB  = 4'h8,
    OP_LBI  = 4'h9,
    OP_CAMQ = 4'ha,
    OP_LQ   = 4'hb,
    OP_INL  = 4'hc,
    OP_XAS  = 4'hd,
    OP_LEI  = 4'he,
    OP_OMG  = 4'hf
  } nc_op_e;
endpackage : nc_pkg

// ### design/nc_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module nc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule : nc_sync2

// ### design/nc_digit_ram.sv
// 4 rows by 8 digits of nibble storage, not cleared by reset
`timescale 1ns/1ps
module nc_digit_ram (
  input  wire logic       clk_i,
  input  wire logic [4:0] addr_i,
  input  wire logic       we_i,
  input  wire logic [3:0] wdata_i,
  output logic      [3:0] rdata_o
);
  logic [3:0] mem [0:31];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[addr_i];
endmodule : nc_digit_ram

// ### design/nc_core.sv
// nibble core datapath, ports, serial unit and program fetch
`timescale 1ns/1ps
// Functional notes
// - 128-bit RAM as 4 rows of 8 digits, row and low digit bits
// - top digit pointer bit ignored, each digit has two pointer aliases
// - increment/decrement exchange skips on 0/15 wrap, not on 7/8
// - fixed exchange reaches row 3 digit 15 whatever the pointer
// - accumulator loads pointer, feeds port latch, reads port, swaps shifter
// - 4-bit adder result to accumulator, carry out to carry flag
// - four-bit port register drives four bidirectional pins
// - port latch loads from RAM and accumulator or program byte
// - eight-bit port pins read into accumulator and RAM digit
// - accumulator/shifter swap copies carry into clock latch
// - feature register written only by load immediate; bit 1 inert
// - counter mode decrements per serial input fall; pulses two cycles wide
// - shift mode shifts left each cycle, serial input into LSB
// - counter mode: serial out follows enable; shift mode: MSB out
// - shift mode with enable clear holds serial out low, shifting continues
// - serial clock is latch in counter mode, latch AND cycle clock otherwise
// - drive bit enables port drivers; clear puts pins in high impedance
// - reset pin low three instruction cycles initializes the device
// - init clears pc, acc, pointer, carry, features, port; sets sync clock
// - address phase drives next address; latch on flag fall
// - data phase memory drives byte; flag one cycle, half duty
// - cycle rate is resonator over 8 or RC over 4
// - 9-bit program counter steps each cycle unless control transfers
module nc_core
  import nc_pkg::*;
#(
  parameter bit RC_BUILD = 1'b0
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        reset_n_i,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             serial_clock_out_o,
  input  wire logic [7:0]  program_bus_i,
  output logic      [7:0]  program_bus_o,
  output logic      [7:0]  program_bus_oe_o,
  output logic             program_addr_msb_o,
  output logic             addr_phase_o,
  input  wire logic [7:0]  port8_i,
  output logic      [7:0]  port8_o,
  output logic      [7:0]  port8_oe_o,
  input  wire logic [3:0]  gport_i,
  output logic      [3:0]  gport_o,
  output logic      [3:0]  gport_oe_o
);
  localparam logic [3:0] DIV  = RC_BUILD ? DIV_RC : DIV_RES;
  localparam logic [3:0] HALF = DIV >> 1;

  logic [3:0] phase_reg;
  logic       inst_clk;
  logic       cycle_end;
  logic       reset_n_s;
  logic       serial_in_s;
  logic [7:0] port8_s;
  logic [3:0] gport_s;
  logic [7:0] bus_s;
  logic [1:0] hold_reg;
  logic       pin_init;
  logic       init;
  logic       ack_reg;
  logic       wr_go;
  logic       cmd_go;
  logic       jump_go;
  nc_op_e     op;
  logic [7:0] imm;
  logic [3:0] acc_reg;
  logic       carry_reg;
  logic       skip_reg;
  logic [1:0] row_reg;
  logic [3:0] dp_reg;
  logic [7:0] q_reg;
  logic [3:0] gport_reg;
  logic [3:0] feat_reg;
  logic [3:0] shift_reg;
  logic       latch_reg;
  logic       si_prev_reg;
  logic       si_fall;
  logic       so_reg;
  logic [8:0] pc_reg;
  logic [8:0] jump_addr_reg;
  logic       jump_pend_reg;
  logic [7:0] instr_reg;
  logic [31:0] rd_data_reg;
  logic [4:0] ram_addr;
  logic       ram_we;
  logic [3:0] ram_wd;
  logic [3:0] ram_rd;
  logic [4:0] sum_mem;
  logic [4:0] sum_imm;
  logic       is_swap;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // instruction cycle: high half is address phase
  always_ff @(posedge clk_i) begin
    if (rst_i || cycle_end) begin
      phase_reg <= 4'h0;
    end else begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  assign cycle_end = (phase_reg == DIV - 4'h1);
  assign inst_clk  = (phase_reg < HALF);

  nc_sync2 #(
    .W(22)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({reset_n_i, serial_in_i, port8_i, gport_i, program_bus_i}),
    .q_o   ({reset_n_s, serial_in_s, port8_s, gport_s, bus_s})
  );

  // reset pin must stay low for whole instruction cycles before acting
  always_ff @(posedge clk_i) begin
    if (rst_i || reset_n_s) begin
      hold_reg <= 2'h0;
    end else if (cycle_end && hold_reg != RESET_HOLD) begin
      hold_reg <= hold_reg + 2'h1;
    end
  end

  assign pin_init = (hold_reg == RESET_HOLD);
  assign init     = rst_i | pin_init;

  // wishbone slave, one wait state, unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wr_go    = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i;
  assign cmd_go   = wr_go & (wb_adr_i == REG_CMD) & (&wb_sel_i[1:0]);
  assign jump_go  = wr_go & (wb_adr_i == REG_PROG) & (&wb_sel_i[1:0]);
  assign op       = nc_op_e'(wb_dat_i[CMD_OP_LSB +: 4]);
  assign imm      = wb_dat_i[CMD_IMM_LSB +: 8];
  assign is_swap  = cmd_go && (op == OP_XAS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_reg <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg && !wb_we_i) begin
      case (wb_adr_i)
        REG_STATE: rd_data_reg <= {8'h00, feat_reg, 1'b0, latch_reg, skip_reg,
                                   carry_reg, 2'h0, row_reg, dp_reg, shift_reg, acc_reg};
        REG_PORTS: rd_data_reg <= {port8_s, 4'h0, gport_s, 4'h0, gport_reg, q_reg};
        REG_PROG:  rd_data_reg <= {8'h00, instr_reg, 7'h00, pc_reg};
        default:   rd_data_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_dat_o = rd_data_reg;

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // data memory addressing, pointer bit 3 never reaches the array
  always_comb begin
    ram_addr = {row_reg, dp_reg[2:0]};
    ram_we   = 1'b0;
    ram_wd   = acc_reg;
    if (cmd_go) begin
      case (op)
        OP_XAD: begin
          ram_addr = {FIXED_ROW, FIXED_DIGIT[2:0]};
          ram_we   = 1'b1;
        end
        OP_XCH, OP_XIS, OP_XDS: ram_we = 1'b1;
        OP_INL: begin
          ram_we = 1'b1;
          ram_wd = port8_s[7:4];
        end
        default: ram_we = 1'b0;
      endcase
    end
  end

  nc_digit_ram u_ram (
    .clk_i   (clk_i),
    .addr_i  (ram_addr),
    .we_i    (ram_we),
    .wdata_i (ram_wd),
    .rdata_o (ram_rd)
  );

  assign sum_mem = {1'b0, acc_reg} + {1'b0, ram_rd} + {4'h0, carry_reg};
  assign sum_imm = {1'b0, acc_reg} + {1'b0, imm[3:0]};

  always_ff @(posedge clk_i) begin
    if (init) begin
      acc_reg <= 4'h0;
    end else if (cmd_go) begin
      case (op)
        OP_ADC:  acc_reg <= sum_mem[3:0];
        OP_AISC: acc_reg <= sum_imm[3:0];
        OP_XOR:  acc_reg <= acc_reg ^ ram_rd;
        OP_XCH, OP_XIS, OP_XDS, OP_XAD: acc_reg <= ram_rd;
        OP_INL:  acc_reg <= port8_s[3:0];
        OP_XAS:  acc_reg <= shift_reg;
        default: acc_reg <= acc_reg;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      carry_reg <= 1'b0;
    end else if (cmd_go && op == OP_ADC) begin
      carry_reg <= sum_mem[4];
    end
  end

  // skip result of the latest command, read back in the state word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      skip_reg <= 1'b0;
    end else if (cmd_go) begin
      case (op)
        OP_ADC:  skip_reg <= sum_mem[4];
        OP_AISC: skip_reg <= sum_imm[4];
        OP_XIS:  skip_reg <= (dp_reg == DP_MAX);
        OP_XDS:  skip_reg <= (dp_reg == DP_MIN);
        default: skip_reg <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      row_reg <= 2'h0;
      dp_reg  <= 4'h0;
    end else if (cmd_go) begin
      case (op)
        OP_XCH: row_reg <= row_reg ^ imm[1:0];
        OP_XIS: begin
          row_reg <= row_reg ^ imm[1:0];
          dp_reg  <= dp_reg + 4'h1;
        end
        OP_XDS: begin
          row_reg <= row_reg ^ imm[1:0];
          dp_reg  <= dp_reg - 4'h1;
        end
        OP_CAB:  dp_reg <= acc_reg;
        OP_LBI:  {row_reg, dp_reg} <= imm[5:0];
        default: dp_reg <= dp_reg;
      endcase
    end
  end

  a_xis_wrap_skip: assert property (
    cmd_go && op == OP_XIS && dp_reg == DP_MAX |=> skip_reg && dp_reg == DP_MIN)
    else $error("increment exchange missed wrap skip");

  a_xis_mid_noskip: assert property (
    cmd_go && op == OP_XIS && dp_reg == 4'h7 && !pin_init |=> !skip_reg)
    else $error("skip raised on 7 to 8 crossing");

  // port latch, four-bit port and feature bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_reg <= 8'h00;
    end else if (cmd_go && op == OP_CAMQ) begin
      q_reg <= {acc_reg, ram_rd};
    end else if (cmd_go && op == OP_LQ) begin
      q_reg <= instr_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      gport_reg <= 4'h0;
    end else if (cmd_go && op == OP_OMG) begin
      gport_reg <= ram_rd;
    end
  end

  // only the load command writes features; bit 1 steers nothing
  always_ff @(posedge clk_i) begin
    if (init) begin
      feat_reg <= 4'h0;
    end else if (cmd_go && op == OP_LEI) begin
      feat_reg <= imm[3:0];
    end
  end

  assign gport_o    = gport_reg;
  assign gport_oe_o = 4'hf;
  assign port8_o    = q_reg;
  assign port8_oe_o = {8{feat_reg[FEAT_DRV]}};

  a_port_hiz: assert property (!feat_reg[FEAT_DRV] |-> port8_oe_o == 8'h00)
    else $error("port driven while drive bit clear");

  // serial unit: shifter or down counter
  assign si_fall = si_prev_reg & ~serial_in_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      si_prev_reg <= 1'b0;
    end else begin
      si_prev_reg <= serial_in_s;
    end
  end

  // swap wins over a count or shift in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_reg <= 4'h0;
    end else if (is_swap) begin
      shift_reg <= acc_reg;
    end else if (feat_reg[FEAT_CNT]) begin
      if (si_fall) begin
        shift_reg <= shift_reg - 4'h1;
      end
    end else if (cycle_end) begin
      shift_reg <= {shift_reg[2:0], serial_in_s};
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      latch_reg <= LATCH_INIT;
    end else if (is_swap) begin
      latch_reg <= carry_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      so_reg <= 1'b0;
    end else if (feat_reg[FEAT_CNT]) begin
      so_reg <= feat_reg[FEAT_SO];
    end else begin
      so_reg <= feat_reg[FEAT_SO] & shift_reg[3];
    end
  end

  assign serial_out_o = so_reg;
  // gated clock is only an output, nothing here runs on it
  assign serial_clock_out_o = feat_reg[FEAT_CNT] ? latch_reg
                                                 : (latch_reg & inst_clk);

  a_count_dec: assert property (
    feat_reg[FEAT_CNT] && si_fall && !is_swap |=> shift_reg == $past(shift_reg) - 4'h1)
    else $error("counter did not step down on falling input");

  a_so_low: assert property (
    !feat_reg[FEAT_CNT] && !feat_reg[FEAT_SO] |=> !serial_out_o)
    else $error("serial out not held low");

  a_sk_counter: assert property (
    feat_reg[FEAT_CNT] |-> serial_clock_out_o == latch_reg)
    else $error("serial clock differs from latch in counter mode");

  a_swap_latch: assert property (
    is_swap && !pin_init |=> latch_reg == $past(carry_reg) && acc_reg == $past(shift_reg))
    else $error("swap did not copy carry and shifter");

  // program fetch: address phase drives pc, byte captured after data phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      jump_pend_reg <= 1'b0;
      jump_addr_reg <= 9'h000;
    end else begin
      jump_pend_reg <= (jump_go | jump_pend_reg) & ~cycle_end;
      if (jump_go) begin
        jump_addr_reg <= wb_dat_i[PROG_PC_LSB +: 9];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      pc_reg <= 9'h000;
    end else if (cycle_end) begin
      if (jump_go) begin
        pc_reg <= wb_dat_i[PROG_PC_LSB +: 9];
      end else if (jump_pend_reg) begin
        pc_reg <= jump_addr_reg;
      end else begin
        pc_reg <= pc_reg + 9'h001;
      end
    end
  end

  // synced bus lags two clocks, so the byte is taken early next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      instr_reg <= 8'h00;
    end else if (phase_reg == SAMPLE_PH) begin
      instr_reg <= bus_s;
    end
  end

  assign program_bus_o      = pc_reg[7:0];
  assign program_bus_oe_o   = {8{inst_clk}};
  assign program_addr_msb_o = pc_reg[8];
  assign addr_phase_o       = inst_clk;

  a_pc_step: assert property (
    cycle_end && !jump_pend_reg && !jump_go && !init |=> pc_reg == $past(pc_reg) + 9'h001)
    else $error("program counter did not step");

  a_addr_drive: assert property (addr_phase_o |-> program_bus_oe_o == 8'hff)
    else $error("bus not driven in address phase");

  a_init_clear: assert property (
    pin_init |=> acc_reg == 4'h0 && pc_reg == 9'h000 && latch_reg && feat_reg == 4'h0)
    else $error("initialization left state set");
endmodule : nc_core

// ### tb/nc_prom_model.sv
// external program memory with address latch, facing the program bus
`timescale 1ns/1ps
module nc_prom_model (
  input  wire logic       clk_i,
  input  wire logic       addr_phase_i,
  input  wire logic       addr_msb_i,
  input  wire logic [7:0] bus_dev_i,
  input  wire logic [7:0] bus_oe_i,
  output logic      [7:0] bus_o
);
  logic [8:0] addr_reg;
  logic [7:0] last_reg;
  logic       ready_reg;
  logic [7:0] mem_byte;
  logic [7:0] far_byte;

  // latch stays transparent while the address phase is high, closes on its fall
  always @(posedge clk_i) begin
    if (addr_phase_i) begin
      addr_reg <= {addr_msb_i, bus_dev_i};
    end
    ready_reg <= !addr_phase_i;
    last_reg  <= bus_o;
  end

  // any address may be read in any order
  assign mem_byte = addr_reg[7:0] ^ {addr_reg[8], 7'h2b};
  // one clock of access delay; released bus shows the inverse of its last level
  assign far_byte = (!addr_phase_i && ready_reg) ? mem_byte : ~last_reg;
  assign bus_o = (bus_dev_i & bus_oe_i) | (far_byte & ~bus_oe_i);
endmodule : nc_prom_model

// ### tb/test_nibble_core_serial_io.sv
// self-checking bench for the nibble core
`timescale 1ns/1ps
module test_nibble_core_serial_io import nc_pkg::*;;
  typedef struct {logic [31:0] e; logic [31:0] m;} nc_note_s;
  nc_note_s    notes[$];
  logic        clk_i, rst_i, cyc, stb, we, ack, reset_n, ser_in, so, sk, msb, aph, ph_q;
  logic [3:0]  adr, gp_o, gp_oe;
  logic [31:0] wdat, rdat;
  logic [7:0]  pb_o, pb_oe, pb_i, p8_o, p8_oe, p8_ext, p8_pin, p, q;
  logic [4:0]  s;
  logic        c;
  int          failures, checks_done, wd, hi_n, per_n, last_hi, last_per;
  logic [7:0]  lt[5] = '{8'h8, 8'h0, 8'h2, 8'h1, 8'h9};
  logic        lso[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  nc_op_e      xo[4] = '{OP_XIS, OP_XIS, OP_XDS, OP_XDS};
  logic [3:0]  d0[4] = '{4'hf, 4'h7, 4'h0, 4'h8};
  logic [3:0]  d1[4] = '{4'h0, 4'h8, 4'hf, 4'h7};
  logic        skp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  assign p8_pin = (p8_o & p8_oe) | (p8_ext & ~p8_oe);

  nc_core #(.RC_BUILD(1'b0)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .reset_n_i(reset_n), .serial_in_i(ser_in), .serial_out_o(so), .serial_clock_out_o(sk),
    .program_bus_i(pb_i), .program_bus_o(pb_o), .program_bus_oe_o(pb_oe),
    .program_addr_msb_o(msb), .addr_phase_o(aph), .port8_i(p8_pin), .port8_o(p8_o),
    .port8_oe_o(p8_oe), .gport_i(gp_o), .gport_o(gp_o), .gport_oe_o(gp_oe));

  nc_prom_model u_prom (.clk_i(clk_i), .addr_phase_i(aph), .addr_msb_i(msb),
    .bus_dev_i(pb_o), .bus_oe_i(pb_oe), .bus_o(pb_i));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task cmd(input nc_op_e op, input logic [7:0] imm);
    wb(1'b1, REG_CMD, {16'h0, imm, 4'h0, op});
  endtask : cmd

  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    wb(1'b0, a, 32'h0);
  endtask : rd

  // read results checked as they appear, oldest note first
  always @(posedge clk_i) begin
    nc_note_s n;
    if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
      n = notes.pop_front();
      chk(rdat & n.m, n.e & n.m);
    end
  end

  // instruction cycle shape, sampled before this edge's updates land
  always @(posedge clk_i) begin
    ph_q <= aph;
    hi_n <= aph ? hi_n + 1 : 0;
    per_n <= (aph && !ph_q) ? 1 : per_n + 1;
    if (aph && !ph_q) last_per <= per_n;
    if (!aph && ph_q) last_hi <= hi_n;
    wd <= wd + 1;
    if (wd == 8000) begin
      failures++;
      test_done();
    end
  end

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat, p8_ext, ph_q} = '0;
    {hi_n, per_n, last_hi, last_per, wd, failures, checks_done} = '0;
    reset_n = 1'b1;
    ser_in = 1'b1;
    void'($urandom(32'hf8de));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    p = 8'($urandom);
    p8_ext <= p;
    repeat (4) @(posedge clk_i);
    cmd(OP_NOP, 8'h0);
    cmd(OP_XOR, 8'h0);
    cmd(OP_LQ, 8'h0);
    cmd(OP_LBI, 8'h05);
    cmd(OP_INL, 8'h0);
    rd(REG_STATE, 32'h00040500 | {28'h0, p[3:0]}, 32'h00f53f0f);
    s = {1'b0, p[3:0]} + {1'b0, p[7:4]};
    c = s[4];
    cmd(OP_ADC, 8'h0);
    rd(REG_STATE, {15'h0, c, 12'h0, s[3:0]}, 32'h0001000f);
    cmd(OP_LBI, 8'h0d);
    cmd(OP_CAMQ, 8'h0);
    rd(REG_PORTS, {24'h0, s[3:0], p[7:4]}, 32'hff);
    cmd(OP_LEI, 8'h4);
    repeat (2) @(posedge clk_i);
    chk(32'(p8_oe), 32'hff);
    chk(32'(p8_o), {24'h0, s[3:0], p[7:4]});
    cmd(OP_OMG, 8'h0);
    repeat (2) @(posedge clk_i);
    chk({gp_oe, gp_o}, {24'h0, 4'hf, p[7:4]});
    cmd(OP_LEI, 8'h0);
    repeat (2) @(posedge clk_i);
    chk(32'(p8_oe), 32'h0);
    cmd(OP_CAB, 8'h0);
    rd(REG_STATE, {20'h0, s[3:0], 8'h0}, 32'h00000f00);
    rd(4'h2, 32'h0, 32'hffffffff);
    wb(1'b1, REG_STATE, 32'hffffffff);
    rd(REG_STATE, 32'h0, 32'h00f00000);
    cmd(OP_XAS, 8'h0);
    rd(REG_STATE, {13'h0, c, 14'h0, 4'hf}, 32'h0004000f);
    // four shifts of ones push the swapped value out
    repeat (40) @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      cmd(OP_LEI, lt[i]);
      repeat (3) @(posedge clk_i);
      chk(32'(so), 32'(lso[i]));
      if (lt[i][0]) chk(32'(sk), 32'(c));
      if (!lt[i][0]) chk(32'(sk), 32'(c & aph));
      rd(REG_STATE, {8'h0, lt[i][3:0], 20'h0}, 32'h00f00000);
    end
    cmd(OP_XAS, 8'h0);
    for (int k = 0; k < 3; k++) begin
      ser_in <= 1'b0;
      repeat (16) @(posedge clk_i);
      ser_in <= 1'b1;
      repeat (16) @(posedge clk_i);
    end
    rd(REG_STATE, 32'h000000c0, 32'h000000f0);
    for (int i = 0; i < 4; i++) begin
      cmd(OP_LBI, {4'h0, d0[i]});
      cmd(xo[i], 8'h0);
      rd(REG_STATE, {14'h0, skp[i], 5'h0, d1[i], 8'h0}, 32'h00020f00);
    end
    cmd(OP_LEI, 8'h0);
    q = 8'($urandom);
    p8_ext <= q;
    repeat (4) @(posedge clk_i);
    cmd(OP_LBI, 8'h00);
    cmd(OP_INL, 8'h0);
    cmd(OP_AISC, 8'h01);
    rd(REG_STATE, {14'h0, q[3:0] == 4'hf, 13'h0, 4'(q[3:0] + 4'h1)}, 32'h0002000f);
    cmd(OP_XAD, 8'h0);
    cmd(OP_LBI, 8'h3f);
    cmd(OP_CAMQ, 8'h0);
    rd(REG_PORTS, {28'h0, 4'(q[3:0] + 4'h1)}, 32'hf);
    chk(32'(last_per), 32'(DIV_RES));
    chk(32'(last_hi), 32'(DIV_RES >> 1));
    // jump written mid data phase so it lands on the coming cycle end
    @(negedge aph);
    wb(1'b1, REG_PROG, 32'h1a5);
    @(posedge aph);
    @(posedge clk_i);
    chk({15'h0, pb_oe, msb, pb_o}, {15'h0, 8'hff, 1'b1, 8'ha5});
    @(posedge aph);
    repeat (4) @(posedge clk_i);
    rd(REG_PROG, {8'h0, 8'ha5 ^ 8'hab, 7'h0, 9'h1a6}, 32'h00ff01ff);
    cmd(OP_LEI, 8'h4);
    reset_n <= 1'b0;
    repeat (12) @(posedge clk_i);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(REG_STATE, 32'h00400000, 32'h00f00000);
    reset_n <= 1'b0;
    repeat (40) @(posedge clk_i);
    @(posedge aph);
    @(posedge clk_i);
    chk({23'h0, msb, pb_o}, 32'h0);
    rd(REG_STATE, 32'h00040000, 32'h00f53f0f);
    chk(32'(gp_o), 32'h0);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    test_done();
  end
endmodule : test_nibble_core_serial_io
